// file: rtl/adc_sequencing_control.v
// Notes on behaviour
// - every finished conversion writes a 10-bit unsigned code into the result register.
// - code equals 1023 times input above low reference over reference span.
// - code saturates at full scale above high reference, zero below low.
// - reference pair comes from three-bit field, bits 15 to 13 of word 0.
// - bit 15 picks low-reference pin; low two bits pick high reference source.
// - internal reference generator powered while its enable bit is set, or while channel 10 is being converted.
// - channel field picks single channel, or the first channel of a sequence.
// - mux opens old channel before closing new; idle channels grounded.
// - channel 10 powers reference generator, not the pin, not the select.
// - mode 00 does exactly one conversion on the selected channel.
// - mode 01 converts selected channel down to channel zero once, then stops.
// - mode 10 repeats selected channel until repeat is left or enable clears.
// - mode 11 repeats descending sequence until repeat left or enable clears.
// - result register loaded first, conversion-done flag set the cycle after.
// - done flag with interrupt enable raises the interrupt request.
// - sample period is 4, 8, 16 or 64 conversion clock cycles.
// - conversion clock is the source divided by any factor 1 to 8.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_sequencing_control #(
   parameter CHANNELS = 12,
   parameter CODE_WIDTH = 10
) (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // register port
   input wire [1:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [15:0] reg_rdata,
   // triggers
   input wire conv_clock_src,
   input wire hw_sample_trigger,
   // analog core
   input wire comparator_high,
   output reg [CODE_WIDTH-1:0] dac_code,
   output reg sample_hold,
   output wire core_power,
   // multiplexer
   output reg [CHANNELS-1:0] channel_close,
   output wire [CHANNELS-1:0] channel_ground,
   // reference
   output wire ref_gen_power,
   output wire ref_pin_enable,
   output wire [1:0] vr_plus_select,
   output wire vr_minus_pin,
   // interrupt
   output wire conversion_irq
);

   // one-hot sequencer states
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_BREAK = 6'h02;
   localparam [5:0] ST_SAMPLE = 6'h04;
   localparam [5:0] ST_CONVERT = 6'h08;
   localparam [5:0] ST_STORE = 6'h10;
   localparam [5:0] ST_FLAG = 6'h20;

   reg [15:0] control_word_0;
   reg [15:0] control_word_1;
   reg [CODE_WIDTH-1:0] conversion_result_reg;
   reg conversion_done_flag;
   reg [5:0] state;
   reg [5:0] next_state;
   reg [3:0] channel;
   reg [3:0] next_channel;
   reg [2:0] div_count;
   reg [6:0] sample_count;
   reg [3:0] bit_index;
   reg trigger_armed;
   reg sw_start;
   reg [6:0] sample_len;
   wire conv_tick;
   wire conversion_enable;
   wire [1:0] sequence_mode_select;
   wire [3:0] input_channel_select;
   wire start_request;
   wire last_in_sequence;
   wire keep_going;
   wire [CODE_WIDTH-1:0] trial_bit;

   assign conversion_enable = control_word_0[`CW0_CONV_EN];
   assign sequence_mode_select = control_word_1[`CW1_SEQ_HI:`CW1_SEQ_LO];
   assign input_channel_select = control_word_1[`CW1_INPUT_CHANNEL_SELECT_HI:`CW1_INPUT_CHANNEL_SELECT_LO];

   // register writes; software start is a pulse, and its stored bit in control_word_0 is never used
   always @(posedge sys_clk) begin
      if (rst) begin
         control_word_0 <= `CW0_RESET;
         control_word_1 <= `CW1_RESET;
         sw_start <= 1'b0;
      end else begin
         sw_start <= reg_write && (reg_addr == `REG_CONTROL_WORD_0) &&
                     reg_wdata[`CW0_SW_START];
         if (reg_write && reg_addr == `REG_CONTROL_WORD_0) begin
            control_word_0 <= reg_wdata;
         end
         if (reg_write && reg_addr == `REG_CONTROL_WORD_1) begin
            control_word_1 <= reg_wdata;
         end
      end
   end

   // done flag: a hardware set in the same cycle beats a software clear
   always @(posedge sys_clk) begin
      if (rst) begin
         conversion_done_flag <= 1'b0;
      end else if (state == ST_FLAG) begin
         conversion_done_flag <= 1'b1;
      end else if (reg_write && reg_addr == `REG_CONTROL_WORD_0) begin
         conversion_done_flag <= reg_wdata[`CW0_DONE_FLAG];
      end
   end

   assign conversion_irq = conversion_done_flag &
                           control_word_0[`CW0_IRQ_EN];

   // read data one cycle after the strobe; unmapped index reads zero
   always @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_read) begin
         case (reg_addr)
            `REG_CONTROL_WORD_0: begin
               reg_rdata <= {control_word_0[15:3], conversion_done_flag,
                             control_word_0[`CW0_CONV_EN], 1'b0};
            end
            `REG_CONTROL_WORD_1: begin
               reg_rdata <= {control_word_1[15:1], ~state[0]};
            end
            `REG_RESULT: begin
               reg_rdata <= {{(16-CODE_WIDTH){1'b0}}, conversion_result_reg};
            end
            default: begin
               reg_rdata <= 16'h0000;
            end
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // conversion clock: one tick every (divider field + 1) source cycles
   // held at zero outside sample and convert, so a sample window is whole ticks
   always @(posedge sys_clk) begin
      if (rst) begin
         div_count <= 3'h0;
      end else if (state != ST_SAMPLE && state != ST_CONVERT) begin
         div_count <= 3'h0;
      end else if (!conv_clock_src) begin
         div_count <= div_count;
      end else if (div_count >= control_word_1[`CW1_DIV_HI:`CW1_DIV_LO]) begin
         div_count <= 3'h0;
      end else begin
         div_count <= div_count + 3'h1;
      end
   end
   assign conv_tick = conv_clock_src &&
                      (div_count >= control_word_1[`CW1_DIV_HI:`CW1_DIV_LO]);

   // sample period select
   always @* begin
      case (control_word_0[`CW0_SHT_HI:`CW0_SHT_LO])
         `SHT_4: sample_len = `SAMPLE_4;
         `SHT_8: sample_len = `SAMPLE_8;
         `SHT_16: sample_len = `SAMPLE_16;
         default: sample_len = `SAMPLE_64;
      endcase
   end

   // a hardware trigger disarms itself until enable goes low again
   always @(posedge sys_clk) begin
      if (rst) begin
         trigger_armed <= 1'b1;
      end else if (!conversion_enable) begin
         trigger_armed <= 1'b1;
      end else if (state == ST_IDLE && start_request &&
                   control_word_1[`CW1_HW_TRIG]) begin
         trigger_armed <= 1'b0;
      end
   end

   assign start_request = conversion_enable && control_word_0[`CW0_CORE_ON] &&
                          (control_word_1[`CW1_HW_TRIG] ?
                           (hw_sample_trigger && trigger_armed) : sw_start);

   // mode is sampled only at the end of a conversion, so a change waits
   assign last_in_sequence = (channel == `CHANNEL_ZERO);
   assign keep_going = conversion_enable;

   // sequencer next state
   always @* begin
      next_state = state;
      next_channel = channel;
      case (state)
         ST_IDLE: begin
            if (start_request) begin
               next_state = ST_BREAK;
               next_channel = input_channel_select;
            end
         end
         ST_BREAK: begin
            next_state = ST_SAMPLE;
         end
         ST_SAMPLE: begin
            if (conv_tick && sample_count == sample_len - 7'h01) begin
               next_state = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            if (conv_tick && bit_index == 4'h0) begin
               next_state = ST_STORE;
            end
         end
         ST_STORE: begin
            next_state = ST_FLAG;
         end
         ST_FLAG: begin
            case (sequence_mode_select)
               `SEQ_SINGLE: begin
                  next_state = ST_IDLE;
               end
               `SEQ_DOWN: begin
                  if (last_in_sequence) begin
                     next_state = ST_IDLE;
                  end else begin
                     next_state = ST_BREAK;
                     next_channel = channel - 4'h1;
                  end
               end
               `SEQ_REPEAT_SINGLE: begin
                  next_state = keep_going ? ST_SAMPLE : ST_IDLE;
               end
               default: begin
                  if (!last_in_sequence) begin
                     next_state = ST_BREAK;
                     next_channel = channel - 4'h1;
                  end else if (keep_going) begin
                     next_state = ST_BREAK;
                     next_channel = input_channel_select;
                  end else begin
                     next_state = ST_IDLE;
                  end
               end
            endcase
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // sequencer registers
   always @(posedge sys_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         channel <= `CHANNEL_ZERO;
      end else begin
         state <= next_state;
         channel <= next_channel;
      end
   end

   // sample timer and successive approximation
   assign trial_bit = {{(CODE_WIDTH-1){1'b0}}, 1'b1} << bit_index;
   always @(posedge sys_clk) begin
      if (rst) begin
         sample_count <= 7'h00;
         bit_index <= `CODE_MSB;
         dac_code <= {CODE_WIDTH{1'b0}};
         sample_hold <= 1'b0;
      end else begin
         case (state)
            ST_SAMPLE: begin
               sample_hold <= 1'b1;
               bit_index <= `CODE_MSB;
               dac_code <= {1'b1, {(CODE_WIDTH-1){1'b0}}};
               if (conv_tick) begin
                  sample_count <= sample_count + 7'h01;
               end
            end
            ST_CONVERT: begin
               sample_hold <= 1'b0;
               sample_count <= 7'h00;
               if (conv_tick) begin
                  // keep the trial bit only if input reached the dac level
                  if (!comparator_high) begin
                     dac_code <= dac_code & ~trial_bit;
                  end
                  if (bit_index != 4'h0) begin
                     bit_index <= bit_index - 4'h1;
                     dac_code <= (comparator_high ? dac_code : (dac_code & ~trial_bit)) |
                                 (trial_bit >> 1);
                  end
               end
            end
            default: begin
               sample_hold <= 1'b0;
               sample_count <= 7'h00;
               bit_index <= `CODE_MSB;
            end
         endcase
      end
   end

   // result loads one cycle ahead of the flag
   always @(posedge sys_clk) begin
      if (rst) begin
         conversion_result_reg <= `RESULT_RESET;
      end else if (state == ST_STORE) begin
         conversion_result_reg <= dac_code;
      end
   end

   // multiplexer: all switches open in break cycle, closed while sampling
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_mux
         always @(posedge sys_clk) begin
            if (rst) begin
               channel_close[ch] <= 1'b0;
            end else begin
               channel_close[ch] <= (channel == ch) &&
                                    (next_state != ST_BREAK) &&
                                    (next_state != ST_IDLE);
            end
         end
         // grounding the middle node of every open switch cuts crosstalk
         assign channel_ground[ch] = ~channel_close[ch];
      end
   endgenerate

   // references; the temperature channel only adds generator power
   assign ref_gen_power = control_word_0[`CW0_REF_GEN_ON] ||
                          (!state[0] && channel == `TEMP_CHANNEL);
   assign ref_pin_enable = control_word_0[`CW0_REF_GEN_ON];
   assign vr_plus_select = (control_word_0[`CW0_SREF_LO+1:`CW0_SREF_LO] == `VRP_AVCC) ?
                           `VRP_AVCC :
                           (control_word_0[`CW0_SREF_LO+1:`CW0_SREF_LO] == `VRP_INTERNAL) ?
                           `VRP_INTERNAL : `VRP_EXTERNAL;
   assign vr_minus_pin = control_word_0[`CW0_SREF_LOW_PIN];
   // turn-on and settling waits are left to software
   assign core_power = control_word_0[`CW0_CORE_ON];

endmodule // adc_sequencing_control

`default_nettype wire

// file: rtl/adc_seq_consts.vh
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// register indices on the plain port
`define REG_CONTROL_WORD_0 2'h0
`define REG_CONTROL_WORD_1 2'h1
`define REG_RESULT 2'h2

// control_word_0 fields
`define CW0_SREF_HI 15
`define CW0_SREF_LO 13
`define CW0_SREF_LOW_PIN 15
`define CW0_SHT_HI 12
`define CW0_SHT_LO 11
`define CW0_REF_GEN_ON 5
`define CW0_CORE_ON 4
`define CW0_IRQ_EN 3
`define CW0_DONE_FLAG 2
`define CW0_CONV_EN 1
`define CW0_SW_START 0

// control_word_1 fields
`define CW1_INPUT_CHANNEL_SELECT_HI 15
`define CW1_INPUT_CHANNEL_SELECT_LO 12
`define CW1_HW_TRIG 10
`define CW1_DIV_HI 7
`define CW1_DIV_LO 5
`define CW1_SEQ_HI 2
`define CW1_SEQ_LO 1
`define CW1_BUSY 0

// reset values
`define CW0_RESET 16'h0000
`define CW1_RESET 16'h0000
`define RESULT_RESET 10'h000

// sequence modes
`define SEQ_SINGLE 2'h0
`define SEQ_DOWN 2'h1
`define SEQ_REPEAT_SINGLE 2'h2
`define SEQ_REPEAT_DOWN 2'h3

// sample period codes and lengths in conversion clock cycles
`define SHT_4 2'h0
`define SHT_8 2'h1
`define SHT_16 2'h2
`define SAMPLE_4 7'h04
`define SAMPLE_8 7'h08
`define SAMPLE_16 7'h10
`define SAMPLE_64 7'h40

// channel and reference codes
`define TEMP_CHANNEL 4'hA
`define CHANNEL_ZERO 4'h0
`define VRP_AVCC 2'h0
`define VRP_INTERNAL 2'h1
`define VRP_EXTERNAL 2'h2

// converter
`define CODE_MSB 4'h9
`define ONE_HOT_ONE 12'h001

`endif

// file: sim/adc_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_asserts #(
   parameter CHANNELS = 12
) (
   // clock, reset and register port
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   // mux and reference outputs
   input wire logic [CHANNELS-1:0] channel_close,
   input wire logic [CHANNELS-1:0] channel_ground,
   input wire logic ref_gen_power,
   input wire logic ref_pin_enable,
   input wire logic [1:0] vr_plus_select,
   input wire logic vr_minus_pin
);
   logic [15:0] cw0;
   logic [3:0] chan;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // shadow of fields only software changes
   always @(posedge sys_clk) begin
      if (rst) begin
         cw0 <= 16'h0000;
         chan <= 4'h0;
      end else if (reg_write && reg_addr == 2'h0) begin
         cw0 <= reg_wdata;
      end else if (reg_write && reg_addr == 2'h1) begin
         chan <= reg_wdata[15:12];
      end
   end
   // a closed switch replaced by another with no open cycle between
   sequence s_closed;
      channel_close != 0;
   endsequence
   sequence s_swap;
      s_closed ##1 (channel_close != 0 && !$stable(channel_close));
   endsequence
   a_ground_inverse: assert property (channel_ground == ~channel_close)
      else $error("idle channel not grounded");
   a_close_onehot: assert property ($onehot0(channel_close))
      else $error("more than one switch closed");
   a_break_make: assert property (not s_swap)
      else $error("switch made before break");
   a_low_ref_pin: assert property (vr_minus_pin == cw0[15])
      else $error("low reference select wrong");
   a_high_ref_sel: assert property (
      vr_plus_select == (cw0[14] ? 2'h2 : {1'h0, cw0[13]}))
      else $error("high reference select wrong");
   a_ref_pin_bit: assert property (ref_pin_enable == cw0[5])
      else $error("reference pin enable wrong");
   a_gen_power_cause: assert property (
      ref_gen_power |-> cw0[5] || chan == 4'hA)
      else $error("generator powered without cause");
   a_temp_power: assert property (
      channel_close[10] |-> ref_gen_power && ref_pin_enable == cw0[5])
      else $error("temperature channel without generator");
endmodule // adc_seq_asserts
bind adc_sequencing_control adc_seq_asserts #(.CHANNELS(CHANNELS)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .channel_close(channel_close),
   .channel_ground(channel_ground), .ref_gen_power(ref_gen_power),
   .ref_pin_enable(ref_pin_enable), .vr_plus_select(vr_plus_select),
   .vr_minus_pin(vr_minus_pin));
`default_nettype wire

// file: sim/adc_sequencing_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencing_control_test;
   logic sys_clk, rst, reg_write, reg_read, conv_clock_src, hw_sample_trigger;
   logic [1:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [9:0] vin, dac_code;
   logic [11:0] channel_close, channel_ground;
   logic [1:0] vr_plus_select;
   logic sample_hold, core_power, ref_gen_power, ref_pin_enable;
   logic vr_minus_pin, conversion_irq, sh_q;
   logic gen_seen = 1'h0;
   logic [3:0] chq[$];
   integer n_mismatch = 0, checked = 0, slen = 0, last_len = 0;
   // ideal comparator: input at or above the trial level
   wire comparator_high = (vin >= dac_code);
   adc_sequencing_control dut (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .conv_clock_src(conv_clock_src),
      .hw_sample_trigger(hw_sample_trigger),
      .comparator_high(comparator_high), .dac_code(dac_code),
      .sample_hold(sample_hold), .core_power(core_power),
      .channel_close(channel_close), .channel_ground(channel_ground),
      .ref_gen_power(ref_gen_power), .ref_pin_enable(ref_pin_enable),
      .vr_plus_select(vr_plus_select), .vr_minus_pin(vr_minus_pin),
      .conversion_irq(conversion_irq));
   function automatic logic [3:0] ch_idx(input logic [11:0] c);
      ch_idx = 4'hF;
      for (int i = 0; i < 12; i++) if (c[i]) ch_idx = 4'(i);
   endfunction
   // channel logged on second sample cycle, once the switch has settled
   always @(posedge sys_clk) begin
      sh_q <= sample_hold;
      slen <= sample_hold ? slen + 1 : 0;
      if (sample_hold && slen == 1) chq.push_back(ch_idx(channel_close));
      if (!sample_hold && sh_q) last_len <= slen;
      if (ref_gen_power && !ref_pin_enable) gen_seen <= 1'h1;
   end
   task close_out;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // the #1 lets register updates settle before callers look
   task wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge sys_clk);
      reg_write <= 1'h0;
      #1;
   endtask
   task rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge sys_clk);
      reg_read <= 1'h0;
      #1 d = reg_rdata;
   endtask
   task run(input logic [15:0] w1, w0, input integer n, stop);
      integer i;
      wr(2'h0, 16'h0010);
      // core turn-on and reference settling before any start
      repeat (20) @(posedge sys_clk);
      chq.delete();
      wr(2'h1, w1);
      wr(2'h0, w0);
      for (i = 0; i < 3000 && chq.size() < n; i++) @(posedge sys_clk);
      if (chq.size() < n) begin
         n_mismatch++;
         $display("[ERR] %0t no conversion", $time);
         close_out;
      end
      if (stop == 1) wr(2'h0, w0 & 16'hFFFC);
      if (stop == 2) wr(2'h1, w1 & 16'hFFF9);
      repeat (400) @(posedge sys_clk);
   endtask
   task q_chk(input integer n, input logic [31:0] pat);
      integer i;
      chk(16'(chq.size()), 16'(n));
      for (i = 0; i < n; i++) chk(16'(chq[i]), 16'(pat[4*i+:4]));
   endtask
   task t_regs;
      logic [15:0] d;
      integer a;
      wr(2'h2, 16'h03FF);
      for (a = 0; a < 4; a++) begin
         rd(2'(a), d);
         chk(d, 16'h0000);
      end
      chk(16'(channel_ground), 16'h0FFF);
      $display("regs done");
   endtask
   task t_refs;
      integer s;
      for (s = 0; s < 8; s++) begin
         wr(2'h0, (16'(s) << 13) | (s % 2 ? 16'h0020 : 16'h0000));
         chk(16'({vr_minus_pin, vr_plus_select}), 16'((s & 4) | (s & 2 ? 2 : s & 1)));
         chk(16'({ref_gen_power, ref_pin_enable}), 16'(s % 2 ? 3 : 0));
      end
      $display("refs done");
   endtask
   task t_single;
      logic [15:0] d;
      integer k;
      for (k = 0; k < 4; k++) begin
         vin <= k == 0 ? 10'h000 : k == 1 ? 10'h3FF : k == 2 ? 10'h2A5 : 10'h15A;
         run(16'h3000, 16'h0013 | (16'(k) << 11) | (k % 2 ? 16'h0008 : 16'h0000), 1, 0);
         q_chk(1, 32'h3);
         chk(16'(last_len), 16'(k == 3 ? 64 : 4 << k));
         chk(16'(conversion_irq), 16'(k % 2));
         chk(16'(core_power), 16'h0001);
         rd(2'h2, d);
         chk(d, 16'(vin));
         rd(2'h2, d);
         chk(d, 16'(vin));
      end
      $display("single done");
   endtask
   task t_div;
      integer k;
      for (k = 1; k < 8; k += 6) begin
         run(16'h1000 | (16'(k) << 5), 16'h0013, 1, 0);
         chk(16'(last_len), 16'(4 * (k + 1)));
      end
      $display("divider done");
   endtask
   task t_modes;
      run(16'h3002, 16'h0013, 4, 0);
      q_chk(4, 32'h0123);
      run(16'h5004, 16'h0013, 3, 1);
      q_chk(3, 32'h555);
      run(16'h4004, 16'h0013, 2, 2);
      q_chk(2, 32'h44);
      run(16'h2006, 16'h0013, 4, 1);
      q_chk(6, 32'h012012);
      $display("modes done");
   endtask
   task t_temp;
      chk(16'(gen_seen), 16'h0000);
      run(16'hA000, 16'h0013, 1, 0);
      q_chk(1, 32'hA);
      chk(16'(gen_seen), 16'h0001);
      $display("temp done");
   endtask
   task t_hw;
      integer k;
      run(16'h2400, 16'h0012, 0, 0);
      for (k = 0; k < 3; k++) begin
         if (k == 2) wr(2'h0, 16'h0010);
         if (k == 2) wr(2'h0, 16'h0012);
         @(posedge sys_clk);
         hw_sample_trigger <= 1'h1;
         @(posedge sys_clk);
         hw_sample_trigger <= 1'h0;
         repeat (100) @(posedge sys_clk);
         chk(16'(chq.size()), 16'(k == 2 ? 2 : 1));
      end
      $display("trigger done");
   endtask
   // free-running 100 MHz clock
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   // reset, then every scenario in turn
   initial begin
      rst = 1'h1;
      reg_addr = 2'h0;
      reg_wdata = 16'h0000;
      reg_write = 1'h0;
      reg_read = 1'h0;
      conv_clock_src = 1'h1;
      hw_sample_trigger = 1'h0;
      vin = 10'h000;
      repeat (3) @(posedge sys_clk);
      rst <= 1'h0;
      t_regs;
      t_refs;
      t_single;
      t_div;
      t_modes;
      t_temp;
      t_hw;
      close_out;
   end
endmodule // adc_sequencing_control_test
`default_nettype wire
